// ---- common/mhc_pkg.sv ----
// Constants and types shared by the modem host register block.
package mhc_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] MHC_ADDR_TX_WORD = 8'hE3;
    localparam logic [7:0] MHC_ADDR_TX_SPECIAL = 8'hE4;
    localparam logic [7:0] MHC_ADDR_RX_WORD = 8'hE5;
    localparam logic [7:0] MHC_ADDR_AM_CMD = 8'hEA;
    // ==========================================================
    // Mode register field values
    localparam logic [3:0] MHC_MODE_QAM_AUTO = 4'hF;
    localparam logic [2:0] MHC_FMT_OFF = 3'h0;
    localparam logic [2:0] MHC_FMT_SPECIAL = 3'h7;
    localparam logic [2:0] MHC_SUB_SYNC = 3'h7;
    localparam logic [2:0] MHC_SUB_HDLC = 3'h6;
    localparam logic [3:0] MHC_MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] MHC_FULL_BITS = 4'h8;
    // ==========================================================
    // Automodem command fields
    localparam int MHC_CMD_F_POS = 5;
    localparam int MHC_CMD_HI = 4;
    localparam int MHC_CMD_LO = 3;
    localparam logic [2:0] MHC_RATE_V22_MAX = 3'h1;
    localparam logic [3:0] MHC_RATE_LINK_BASE = 4'h8;
    localparam logic [15:0] MHC_RESET_WORD = 16'h0000;
    typedef enum logic [2:0] {
        MHC_AC_NONE = 3'h0,
        MHC_AC_STOP = 3'h1,
        MHC_AC_RETRAIN = 3'h2,
        MHC_AC_CALL = 3'h3,
        MHC_AC_ANSWER = 3'h4,
        MHC_AC_RENEG = 3'h5
    } mhc_cmd_t;
    // ==========================================================
    // Bit timing
    localparam int MHC_CLK_HZ = 250000000;
    localparam int MHC_MAX_BPS = 14400;
    localparam int MHC_BIT_DIV = MHC_CLK_HZ / MHC_MAX_BPS;
    typedef enum logic [2:0] {
        MHC_SER_IDLE = 3'h0,
        MHC_SER_START = 3'h1,
        MHC_SER_DATA = 3'h3,
        MHC_SER_PAR = 3'h2,
        MHC_SER_STOP = 3'h6
    } mhc_ser_t;
endpackage

// ---- logic/mhc_tx_ser.sv ----
// Transmit character serialiser for synchronous and start-stop framing.
`timescale 1ns/1ps
module mhc_tx_ser
    import mhc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bit_en,
    input wire logic char_valid,
    input wire logic [7:0] char_data,
    input wire logic char_ovs,
    input wire logic start_stop,
    input wire logic [3:0] data_bits,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic two_stop,
    output logic char_take,
    output logic tx_bit,
    output logic tx_busy
);
    typedef struct packed {
        mhc_ser_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic par;
        logic [1:0] stops;
        logic take;
        logic bit_out;
    } mhc_ser_state_t;

    mhc_ser_state_t cur_ff;
    mhc_ser_state_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.take = 1'b0;
        case (cur_ff.st)
            MHC_SER_IDLE: begin
                nxt_ff.bit_out = 1'b1;
                if (bit_en && char_valid && !cur_ff.take) begin
                    nxt_ff.take = 1'b1;
                    nxt_ff.sh = char_data;
                    nxt_ff.par = parity_odd;
                    nxt_ff.stops = (two_stop ? 2'd2 : 2'd1)
                        - {1'b0, char_ovs};
                    if (start_stop) begin
                        nxt_ff.bit_out = 1'b0;
                        nxt_ff.cnt = data_bits;
                        nxt_ff.st = MHC_SER_START;
                    end else begin
                        nxt_ff.bit_out = char_data[0];
                        nxt_ff.sh = {1'b0, char_data[7:1]};
                        nxt_ff.cnt = MHC_FULL_BITS - 4'd1;
                        nxt_ff.st = MHC_SER_DATA;
                    end
                end
            end
            MHC_SER_START, MHC_SER_DATA: begin
                if (bit_en) begin
                    if (cur_ff.cnt == 4'd0) begin
                        nxt_ff.bit_out = start_stop ? cur_ff.par : 1'b1;
                        nxt_ff.st = (start_stop && parity_en) ?
                            MHC_SER_PAR : MHC_SER_STOP;
                        if (!start_stop) begin
                            nxt_ff.st = MHC_SER_IDLE;
                        end else if (!parity_en) begin
                            nxt_ff.bit_out = 1'b1;
                        end
                    end else begin
                        nxt_ff.bit_out = cur_ff.sh[0];
                        nxt_ff.par = cur_ff.par ^ cur_ff.sh[0];
                        nxt_ff.sh = {1'b0, cur_ff.sh[7:1]};
                        nxt_ff.cnt = cur_ff.cnt - 4'd1;
                        nxt_ff.st = MHC_SER_DATA;
                    end
                end
            end
            MHC_SER_PAR: begin
                if (bit_en) begin
                    nxt_ff.bit_out = 1'b1;
                    nxt_ff.st = MHC_SER_STOP;
                end
            end
            MHC_SER_STOP: begin
                if (bit_en) begin
                    if (cur_ff.stops <= 2'd1) begin
                        nxt_ff.st = MHC_SER_IDLE;
                    end else begin
                        nxt_ff.stops = cur_ff.stops - 2'd1;
                    end
                end
            end
            default: begin
                nxt_ff.st = MHC_SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{st: MHC_SER_IDLE, bit_out: 1'b1, default: '0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign char_take = cur_ff.take;
    assign tx_bit = cur_ff.bit_out;
    assign tx_busy = (cur_ff.st != MHC_SER_IDLE);
endmodule

// ---- logic/mhc_host_regs.sv ----
// Host command and data registers of the line modem.
`timescale 1ns/1ps
// What this block does
// - Commands ignored unless both mode registers select QAM automodem.
// - Decode bits 5..0: stop, retrain, call, answer, re-negotiate, bitrate.
// - Low-speed protocols: fast flag in answer start suppresses answer tone.
// - High-speed protocols: fast flag selects quick echo-canceller training.
// - Bitrate field caps negotiated rate, 111 is 14400 down to 000 1200.
// - Start command runs full start-up alone and reports events.
// - Connected link shows rate as status code 1000 to 1111.
// - Remote retrain or re-negotiation answered alone, progress reported.
// - General control bit 10 selects one-byte or two-byte transmit width.
// - Synchronous and HDLC send all eight bits, bit 0 first.
// - Start-stop sends configured data bits LSB first, adds framing.
// - One-byte mode: start-stop secondary address writes send one stop bit in place of two; no change with one stop bit set.
// - Two-byte mode: secondary address sends one character, no overspeed.
// - Receive width change takes effect only after reset.
// - Synchronous and HDLC receive: earliest bit in bit 0, latest bit 7.
// - Start-stop receive: data bits from bit 0, unused bits zero.
// - HDLC receive delivers check sequence right after last data character.
module mhc_host_regs
    import mhc_pkg::*;
#(
    parameter logic [15:0] BIT_DIV = 16'(MHC_BIT_DIV)
)(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic ctl_two_byte,
    input wire logic [3:0] tx_mode_sel,
    input wire logic [3:0] rx_mode_sel,
    input wire logic prog_flag,
    input wire logic [2:0] tx_fmt,
    input wire logic [2:0] tx_sub,
    input wire logic tx_two_stop,
    input wire logic tx_parity_odd,
    input wire logic [2:0] rx_fmt,
    input wire logic [2:0] rx_sub,
    input wire logic rx_bit,
    input wire logic rx_bit_en,
    input wire logic rx_fcs_in,
    input wire logic eng_evt,
    input wire logic [3:0] eng_evt_code,
    input wire logic eng_link_up,
    input wire logic [2:0] eng_rate,
    input wire logic rem_retrain_req,
    input wire logic rem_reneg_req,
    output logic [15:0] reg_rdata,
    output logic am_cmd_pulse,
    output logic [2:0] am_cmd,
    output logic [2:0] am_max_rate,
    output logic am_no_ans_tone,
    output logic am_fast_ec,
    output logic am_auto_resp,
    output logic [3:0] am_status,
    output logic am_status_evt,
    output logic tx_ready,
    output logic tx_line,
    output logic rx_ready,
    output logic rx_is_fcs,
    output logic rx_overrun
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [15:0] rdata;
        logic cmd_pulse;
        logic [2:0] cmd;
        logic [2:0] max_rate;
        logic no_ans_tone;
        logic fast_ec;
        logic auto_resp;
        logic [3:0] status;
        logic status_evt;
        logic rx_two;
        logic rx_two_set;
        logic [15:0] tx_hold;
        logic [1:0] tx_cnt;
        logic tx_ovs;
        logic [15:0] div;
        logic bit_en;
        logic [7:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [15:0] rx_word;
        logic rx_half;
        logic rx_ready;
        logic rx_fcs;
        logic rx_ovr;
        logic tx_line;
    } mhc_state_t;

    mhc_state_t cur_ff;
    mhc_state_t nxt_ff;

    logic ser_take;
    logic ser_bit;
    logic ser_busy;
    logic tx_ss;
    logic [3:0] tx_nbits;
    logic [3:0] rx_nbits;
    logic rx_on;
    logic [7:0] rx_char;
    logic rx_done;
    logic auto_ok;
    logic [2:0] dec;

    // ==========================================================
    // Helpers
    function automatic logic [3:0] data_bits(input logic [2:0] fmt,
                                             input logic [2:0] sub);
        if (fmt == MHC_FMT_SPECIAL) begin
            data_bits = MHC_FULL_BITS;
        end else begin
            data_bits = MHC_MIN_DATA_BITS + {2'b00, sub[2:1]};
        end
    endfunction

    function automatic logic [2:0] cmd_decode(input logic [5:0] w);
        if (w == 6'h00) begin
            cmd_decode = MHC_AC_STOP;
        end else begin
            case ({w[MHC_CMD_F_POS], w[MHC_CMD_HI:MHC_CMD_LO]})
                3'b001, 3'b101: cmd_decode = MHC_AC_RETRAIN;
                3'b010, 3'b110: cmd_decode = MHC_AC_CALL;
                3'b011, 3'b111: cmd_decode = MHC_AC_ANSWER;
                3'b100: cmd_decode = MHC_AC_RENEG;
                default: cmd_decode = MHC_AC_NONE;
            endcase
        end
    endfunction

    assign tx_ss = (tx_fmt != MHC_FMT_SPECIAL);
    assign tx_nbits = data_bits(tx_fmt, tx_sub);
    assign rx_nbits = data_bits(rx_fmt, rx_sub);
    assign rx_on = (rx_fmt != MHC_FMT_OFF) && rx_bit_en;
    assign rx_done = rx_on && (cur_ff.rx_cnt == rx_nbits - 4'd1);
    assign auto_ok = (tx_mode_sel == MHC_MODE_QAM_AUTO)
        && (rx_mode_sel == MHC_MODE_QAM_AUTO);
    assign dec = cmd_decode(reg_wdata[5:0]);

    always_comb begin
        rx_char = cur_ff.rx_sh;
        rx_char[cur_ff.rx_cnt[2:0]] = rx_bit;
    end

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.cmd_pulse = 1'b0;
        nxt_ff.auto_resp = 1'b0;
        nxt_ff.status_evt = 1'b0;
        nxt_ff.tx_line = ser_bit;

        // ======================================================
        // Receive width latch
        if (!cur_ff.rx_two_set) begin
            nxt_ff.rx_two = ctl_two_byte;
            nxt_ff.rx_two_set = 1'b1;
        end

        // ======================================================
        // Bit-rate divider
        nxt_ff.bit_en = 1'b0;
        if (cur_ff.div == 16'h0000) begin
            nxt_ff.div = BIT_DIV - 16'h0001;
            nxt_ff.bit_en = 1'b1;
        end else begin
            nxt_ff.div = cur_ff.div - 16'h0001;
        end

        // ======================================================
        // Automodem command register
        if (reg_wr && reg_addr == MHC_ADDR_AM_CMD && auto_ok
            && dec != MHC_AC_NONE) begin
            nxt_ff.cmd_pulse = 1'b1;
            nxt_ff.cmd = dec;
            if (dec != MHC_AC_STOP) begin
                nxt_ff.max_rate = reg_wdata[2:0];
                nxt_ff.no_ans_tone = reg_wdata[MHC_CMD_F_POS]
                    && dec == MHC_AC_ANSWER
                    && reg_wdata[2:0] <= MHC_RATE_V22_MAX;
                nxt_ff.fast_ec = reg_wdata[MHC_CMD_F_POS]
                    && reg_wdata[2:0] > MHC_RATE_V22_MAX;
            end
        end

        // ======================================================
        // Requests from the remote modem are answered without the host
        if (rem_retrain_req || rem_reneg_req) begin
            nxt_ff.auto_resp = 1'b1;
        end

        // ======================================================
        // Automodem status
        if (eng_evt) begin
            nxt_ff.status = eng_evt_code;
            nxt_ff.status_evt = 1'b1;
        end
        if (eng_link_up) begin
            nxt_ff.status = MHC_RATE_LINK_BASE
                | {1'b0, eng_rate};
            nxt_ff.status_evt = 1'b1;
        end

        // ======================================================
        // Transmit holding register
        if (ser_take && cur_ff.tx_cnt != 2'd0) begin
            nxt_ff.tx_hold = {cur_ff.tx_hold[7:0], 8'h00};
            nxt_ff.tx_cnt = cur_ff.tx_cnt - 2'd1;
            nxt_ff.tx_ovs = 1'b0;
        end
        if (reg_wr && reg_addr == MHC_ADDR_TX_WORD) begin
            if (ctl_two_byte) begin
                nxt_ff.tx_hold = reg_wdata;
                nxt_ff.tx_cnt = 2'd2;
            end else begin
                nxt_ff.tx_hold = {reg_wdata[7:0], 8'h00};
                nxt_ff.tx_cnt = 2'd1;
            end
            nxt_ff.tx_ovs = 1'b0;
        end
        if (reg_wr && reg_addr == MHC_ADDR_TX_SPECIAL) begin
            nxt_ff.tx_hold = {reg_wdata[7:0], 8'h00};
            nxt_ff.tx_cnt = 2'd1;
            nxt_ff.tx_ovs = !ctl_two_byte && tx_ss;
        end

        // ======================================================
        // Receive character assembly
        if (rx_on) begin
            if (rx_done) begin
                nxt_ff.rx_sh = 8'h00;
                nxt_ff.rx_cnt = 4'd0;
            end else begin
                nxt_ff.rx_sh = rx_char;
                nxt_ff.rx_cnt = cur_ff.rx_cnt + 4'd1;
            end
        end
        if (reg_rd && reg_addr == MHC_ADDR_RX_WORD) begin
            nxt_ff.rdata = cur_ff.rx_word;
            nxt_ff.rx_ready = 1'b0;
        end else if (reg_rd) begin
            nxt_ff.rdata = MHC_RESET_WORD;
        end
        if (rx_done) begin
            // Check-sequence bytes flow through like data bytes.
            nxt_ff.rx_fcs = rx_fcs_in;
            if (cur_ff.rx_two && !cur_ff.rx_half) begin
                nxt_ff.rx_word = {rx_char, 8'h00};
                nxt_ff.rx_half = 1'b1;
            end else begin
                if (cur_ff.rx_two) begin
                    nxt_ff.rx_word = {cur_ff.rx_word[15:8], rx_char};
                end else begin
                    nxt_ff.rx_word = {8'h00, rx_char};
                end
                nxt_ff.rx_half = 1'b0;
                nxt_ff.rx_ovr = cur_ff.rx_ovr || (cur_ff.rx_ready
                    && !(reg_rd && reg_addr == MHC_ADDR_RX_WORD));
                nxt_ff.rx_ready = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{tx_line: 1'b1, default: '0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ==========================================================
    // Transmit serialiser
    mhc_tx_ser u_ser (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bit_en(cur_ff.bit_en),
        .char_valid(cur_ff.tx_cnt != 2'd0),
        .char_data(cur_ff.tx_hold[15:8]),
        .char_ovs(cur_ff.tx_ovs),
        .start_stop(tx_ss),
        .data_bits(tx_nbits),
        .parity_en(tx_sub[0]),
        .parity_odd(tx_parity_odd),
        .two_stop(tx_two_stop),
        .char_take(ser_take),
        .tx_bit(ser_bit),
        .tx_busy(ser_busy)
    );

    assign reg_rdata = cur_ff.rdata;
    assign am_cmd_pulse = cur_ff.cmd_pulse;
    assign am_cmd = cur_ff.cmd;
    assign am_max_rate = cur_ff.max_rate;
    assign am_no_ans_tone = cur_ff.no_ans_tone;
    assign am_fast_ec = cur_ff.fast_ec;
    assign am_auto_resp = cur_ff.auto_resp;
    assign am_status = cur_ff.status;
    assign am_status_evt = cur_ff.status_evt;
    assign tx_ready = (cur_ff.tx_cnt == 2'd0);
    assign tx_line = cur_ff.tx_line;
    assign rx_ready = cur_ff.rx_ready;
    assign rx_is_fcs = cur_ff.rx_fcs;
    assign rx_overrun = cur_ff.rx_ovr;
endmodule

// ---- bench/mhc_host_regs_assertions.sv ----
// Concurrent checks on the ports of the host register block.
`timescale 1ns/1ps
module mhc_host_regs_assertions
    import mhc_pkg::*;
(
    input logic clk_sys,
    input logic rst_n,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic [3:0] tx_mode_sel,
    input logic [3:0] rx_mode_sel,
    input logic rx_bit_en,
    input logic eng_link_up,
    input logic [2:0] eng_rate,
    input logic rem_retrain_req,
    input logic rem_reneg_req,
    input logic am_cmd_pulse,
    input logic [2:0] am_cmd,
    input logic [2:0] am_max_rate,
    input logic am_no_ans_tone,
    input logic am_fast_ec,
    input logic am_auto_resp,
    input logic [3:0] am_status,
    input logic am_status_evt,
    input logic tx_ready,
    input logic rx_ready
);
    // ==========================================================
    // Expected decode of the command word
    logic [2:0] exp_cmd;
    logic [15:0] w_q;
    logic [2:0] c_q;
    always_comb begin
        if (reg_wdata[5:0] == 6'h00) begin
            exp_cmd = MHC_AC_STOP;
        end else if (reg_wdata[5:3] == 3'h0) begin
            exp_cmd = MHC_AC_NONE;
        end else if (reg_wdata[4:3] == 2'h0) begin
            exp_cmd = MHC_AC_RENEG;
        end else begin
            exp_cmd = 3'(reg_wdata[4:3]) + 3'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        w_q <= reg_wdata;
        c_q <= exp_cmd;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_cmd_wr;
        reg_wr && reg_addr == MHC_ADDR_AM_CMD;
    endsequence
    sequence s_cmd_ok;
        s_cmd_wr ##0 (tx_mode_sel == MHC_MODE_QAM_AUTO &&
            rx_mode_sel == MHC_MODE_QAM_AUTO && exp_cmd != MHC_AC_NONE);
    endsequence
    sequence s_cmd_set;
        s_cmd_ok ##0 exp_cmd != MHC_AC_STOP;
    endsequence
    sequence s_cmd_flag;
        s_cmd_set ##0 exp_cmd != MHC_AC_RENEG;
    endsequence
    cmd_accept_a: assert property (
        s_cmd_ok |=> am_cmd_pulse && am_cmd == c_q)
        else $error("command write not decoded");
    cmd_ignore_a: assert property (
        s_cmd_wr ##0 (tx_mode_sel != MHC_MODE_QAM_AUTO ||
        rx_mode_sel != MHC_MODE_QAM_AUTO)
        |=> !am_cmd_pulse && $stable(am_cmd))
        else $error("command taken outside automodem mode");
    rate_cap_a: assert property (
        s_cmd_set |=> am_max_rate == w_q[2:0])
        else $error("rate cap wrong");
    no_tone_a: assert property (
        s_cmd_flag |=> am_no_ans_tone == (c_q == MHC_AC_ANSWER &&
        w_q[5] && w_q[2:0] <= 3'h1))
        else $error("answer tone flag wrong");
    fast_ec_a: assert property (
        s_cmd_flag |=> am_fast_ec == (w_q[5] && w_q[2:0] >= 3'h2))
        else $error("fast training flag wrong");
    link_rate_a: assert property (
        eng_link_up |=> am_status == {1'b1, $past(eng_rate)} &&
        am_status_evt)
        else $error("link rate status wrong");
    remote_resp_a: assert property (
        rem_retrain_req || rem_reneg_req |=> am_auto_resp)
        else $error("remote request not answered");
    tx_load_a: assert property (
        reg_wr && (reg_addr == MHC_ADDR_TX_WORD ||
        reg_addr == MHC_ADDR_TX_SPECIAL) |=> !tx_ready)
        else $error("transmit ready not cleared");
    rx_clear_a: assert property (
        reg_rd && reg_addr == MHC_ADDR_RX_WORD && !rx_bit_en |=> !rx_ready)
        else $error("receive ready not cleared");
endmodule

// ---- bench/mhc_host_model.sv ----
// Behavioural host controller that drives the register access strobes.
`timescale 1ns/1ps
module mhc_host_model
    import mhc_pkg::*;
(
    input logic clk_sys,
    input logic prog_flag,
    input logic tx_ready,
    input logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    task automatic write(input logic [7:0] addr, input logic [15:0] data);
        int t;
        t = 0;
        @(negedge clk_sys);
        while (t < 300 && ((addr == MHC_ADDR_AM_CMD && !prog_flag) ||
            (addr inside {MHC_ADDR_TX_WORD, MHC_ADDR_TX_SPECIAL} &&
            !tx_ready))) begin
            @(negedge clk_sys);
            t++;
        end
        reg_addr = addr;
        reg_wdata = (addr == MHC_ADDR_AM_CMD) ? 16'(data[5:0]) : data;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic read(input logic [7:0] addr, output logic [15:0] data);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        data = reg_rdata;
    endtask
endmodule

// ---- bench/test_mhc_host_regs.sv ----
// Self-checking bench for the modem host register block.
`timescale 1ns/1ps
module test_mhc_host_regs
    import mhc_pkg::*;
    ;
    localparam int DIV = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic ctl_two_byte = 1'b0, prog_flag = 1'b1;
    logic [3:0] tx_mode_sel = 4'hF, rx_mode_sel = 4'hF;
    logic [2:0] tx_fmt = 3'h0, tx_sub = 3'h0, rx_fmt = 3'h0, rx_sub = 3'h0;
    logic tx_two_stop = 1'b0, tx_parity_odd = 1'b1;
    logic rx_bit = 1'b0, rx_bit_en = 1'b0, rx_fcs_in = 1'b0;
    logic eng_evt = 1'b0, eng_link_up = 1'b0;
    logic [3:0] eng_evt_code = 4'h0;
    logic [2:0] eng_rate = 3'h0;
    logic rem_retrain_req = 1'b0, rem_reneg_req = 1'b0;
    logic [2:0] am_cmd, am_max_rate;
    logic [3:0] am_status;
    logic am_cmd_pulse, am_no_ans_tone, am_fast_ec, am_auto_resp;
    logic am_status_evt, tx_ready, tx_line, rx_ready, rx_is_fcs, rx_overrun;
    int n_fail = 0;
    int num_checks = 0;
    logic [15:0] cmds [5] = '{16'h0000, 16'h000D, 16'h0017, 16'h0039,
        16'h0024};
    mhc_cmd_t exps [5] = '{MHC_AC_STOP, MHC_AC_RETRAIN, MHC_AC_CALL,
        MHC_AC_ANSWER, MHC_AC_RENEG};
    mhc_host_regs #(.BIT_DIV(16'h0004)) u_dut (.*);
    mhc_host_model u_host (.*);
    always #2 clk_sys = ~clk_sys;
    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmd(input logic [15:0] w, input logic p);
        u_host.write(MHC_ADDR_AM_CMD, w);
        chk("pulse", 16'(am_cmd_pulse), 16'(p));
    endtask
    task automatic rx_bits(input logic [7:0] d, input int n, input logic f);
        for (int i = 0; i < n; i++) begin
            rx_bit = d[i];
            rx_fcs_in = f;
            rx_bit_en = 1'b1;
            cyc(1);
            rx_bit_en = 1'b0;
            cyc(1);
        end
    endtask
    task automatic rx_char(input logic [7:0] d, input int n, input logic f,
        input logic [15:0] exp);
        rx_bits(d, n, f);
        chk("rx_ready", 16'(rx_ready), 16'h0001);
        chk("rx_is_fcs", 16'(rx_is_fcs), 16'(f));
        u_host.read(MHC_ADDR_RX_WORD, v);
        chk("rx word", v, exp);
        chk("rx_ready", 16'(rx_ready), 16'h0000);
    endtask
    task automatic frame(input int n, input logic [15:0] exp);
        logic [15:0] got;
        int t;
        got = 16'h0000;
        t = 0;
        while (tx_line !== 1'b0 && t < 300) begin
            cyc(1);
            t++;
        end
        chk("start", 16'(tx_line), 16'h0000);
        cyc(1);
        for (int i = 0; i < n; i++) begin
            got[i] = tx_line;
            cyc(DIV);
        end
        chk("frame", got, exp);
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        chk("idle", 16'(tx_line), 16'h0001);
        foreach (cmds[i]) begin
            cmd(cmds[i], 1'b1);
            chk("am_cmd", 16'(am_cmd), 16'(exps[i]));
        end
        for (int r = 0; r < 8; r++) begin
            cmd(16'h0038 | 16'(r), 1'b1);
            chk("rate", 16'(am_max_rate), 16'(r));
            chk("no tone", 16'(am_no_ans_tone), 16'(r < 2));
            chk("fast ec", 16'(am_fast_ec), 16'(r >= 2));
        end
        cmd(16'h0030, 1'b1);
        chk("no tone", 16'(am_no_ans_tone), 16'h0000);
        tx_mode_sel = 4'hE;
        cmd(16'h0000, 1'b0);
        chk("am_cmd", 16'(am_cmd), 16'(MHC_AC_CALL));
        tx_mode_sel = 4'hF;
        rx_mode_sel = 4'h0;
        cmd(16'h0000, 1'b0);
        rx_mode_sel = 4'hF;
        cmd(16'h0005, 1'b0);
        u_host.write(8'h10, 16'h0000);
        chk("pulse", 16'(am_cmd_pulse), 16'h0000);
        u_host.read(MHC_ADDR_AM_CMD, v);
        chk("cmd read", v, 16'h0000);
        eng_rate = 3'h5;
        eng_link_up = 1'b1;
        cyc(1);
        eng_link_up = 1'b0;
        chk("status", 16'(am_status), 16'h000D);
        eng_evt_code = 4'h3;
        eng_evt = 1'b1;
        cyc(1);
        eng_evt = 1'b0;
        chk("status", 16'(am_status), 16'h0003);
        chk("evt", 16'(am_status_evt), 16'h0001);
        rem_reneg_req = 1'b1;
        cyc(1);
        rem_reneg_req = 1'b0;
        chk("auto resp", 16'(am_auto_resp), 16'h0001);
        rx_fmt = 3'h7;
        rx_sub = 3'h7;
        rx_char(8'hB4, 8, 1'b0, 16'h00B4);
        rx_sub = 3'h6;
        rx_char(8'h9C, 8, 1'b0, 16'h009C);
        rx_char(8'h47, 8, 1'b1, 16'h0047);
        rx_fmt = 3'h6;
        rx_sub = 3'h2;
        rx_char(8'hED, 6, 1'b0, 16'h002D);
        ctl_two_byte = 1'b1;
        rx_fmt = 3'h7;
        rx_sub = 3'h7;
        rx_char(8'h3C, 8, 1'b0, 16'h003C);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        rx_bits(8'h12, 8, 1'b0);
        chk("rx_ready", 16'(rx_ready), 16'h0000);
        rx_char(8'h34, 8, 1'b0, 16'h1234);
        chk("overrun", 16'(rx_overrun), 16'h0000);
        repeat (4) rx_bits(8'h01, 8, 1'b0);
        chk("overrun", 16'(rx_overrun), 16'h0001);
        tx_fmt = 3'h6;
        tx_sub = 3'h6;
        u_host.write(MHC_ADDR_TX_WORD, 16'h3CA5);
        chk("tx_ready", 16'(tx_ready), 16'h0000);
        frame(10, {6'h00, 1'b1, 8'h3C, 1'b0});
        frame(10, {6'h00, 1'b1, 8'hA5, 1'b0});
        u_host.write(MHC_ADDR_TX_SPECIAL, 16'h7796);
        frame(10, {6'h00, 1'b1, 8'h96, 1'b0});
        cyc(15 * DIV);
        chk("idle", 16'(tx_line), 16'h0001);
        tx_sub = 3'h7;
        u_host.write(MHC_ADDR_TX_SPECIAL, 16'h0003);
        frame(11, {5'h00, 1'b1, ~^8'h03, 8'h03, 1'b0});
        cyc(20 * DIV);
        ctl_two_byte = 1'b0;
        tx_sub = 3'h6;
        tx_two_stop = 1'b1;
        u_host.write(MHC_ADDR_TX_SPECIAL, 16'h00C3);
        frame(10, {6'h00, 1'b1, 8'hC3, 1'b0});
        cyc(20 * DIV);
        tx_fmt = 3'h7;
        tx_sub = 3'h7;
        u_host.write(MHC_ADDR_TX_WORD, 16'h005A);
        frame(8, 16'h005A);
        conclude();
    end
    initial begin
        cyc(20000);
        n_fail++;
        conclude();
    end
endmodule
bind mhc_host_regs mhc_host_regs_assertions u_chk (.*);
